/* usb_bridge_pkg.sv */
/*
  constants shared by the usb-to-user-bus bridge: request codes, record
  codes, register offsets, reset values and fixed byte sizes.
  assumes nothing of its surroundings.
*/
package usb_bridge_pkg;
  // control request identifiers carried in the request field
  localparam logic [7:0] REQ_FW_REVISION  = 8'ha6;
  localparam logic [7:0] REQ_MEDIA_LOAD   = 8'haf;
  localparam logic [7:0] REQ_CONFIG_CHECK = 8'hb5;
  localparam logic [7:0] REQ_SELECT       = 8'hb7;
  localparam logic [7:0] REQ_BOARD_TYPE   = 8'hb9;
  localparam logic [7:0] REQ_READ_LENGTH  = 8'hbb;
  localparam logic [7:0] REQ_DESELECT     = 8'hbd;
  localparam logic [7:0] REQ_REG_ACCESS   = 8'hbe;
  localparam logic [7:0] REQ_CLEAR        = 8'h90;

  // request-type field: bits 6:5 hold the type, bit 7 the direction
  localparam logic [1:0] TYPE_VENDOR   = 2'h2;
  localparam int         TYPE_LSB      = 5;
  localparam int         DIR_BIT       = 7;

  // bulk record layout
  localparam logic [7:0] REC_ADDRESS   = 8'h00;
  localparam logic [7:0] REC_DATA      = 8'h01;
  localparam logic [2:0] REC_PAYLOAD   = 3'h4;
  localparam int         WORD_BYTES_LOG2 = 2;
  localparam logic [1:0] LAST_BYTE_IDX = 2'h3;

  // configuration register offsets and reset values
  localparam logic [15:0] REG_USER_BUS_DISABLE = 16'hdf39;
  localparam logic [7:0]  RST_USER_BUS_DISABLE = 8'h00;
  localparam logic [31:0] RST_ADDRESS          = 32'h0000_0000;

  // one-character answer of the configuration check
  localparam logic [7:0] CHAR_CONFIGURED   = 8'h31;
  localparam logic [7:0] CHAR_UNCONFIGURED = 8'h30;

  // fifo in the read path
  localparam int FIFO_DEPTH = 16;
  localparam int WORD_W     = 32;
endpackage : usb_bridge_pkg

/* word_fifo.sv */
/*
  word fifo with valid/ready on both sides, storage in flip-flops.
  assumes a single clock and that the pusher honours in_ready.
*/
`timescale 1ns/1ns
module word_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wptr;
    logic [AW:0]                 rptr;
  } fifo_s;

  fifo_s st_reg;
  fifo_s st_next;
  logic  full;
  logic  empty;

  // extra pointer bit tells full from empty without a counter
  assign empty     = st_reg.wptr == st_reg.rptr;
  assign full      = (st_reg.wptr[AW] != st_reg.rptr[AW]) &&
                     (st_reg.wptr[AW-1:0] == st_reg.rptr[AW-1:0]);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = st_reg.mem[st_reg.rptr[AW-1:0]];

  // push and pop may share a cycle
  always_comb begin
    st_next = st_reg;
    if (in_valid && !full) begin
      st_next.mem[st_reg.wptr[AW-1:0]] = in_data;
      st_next.wptr = st_reg.wptr + 1'b1;
    end
    if (out_ready && !empty) begin
      st_next.rptr = st_reg.rptr + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule : word_fifo

/* usb_to_user_bus_bridge.sv */
/*
  bridge from a usb front end (setup fields, ep0 byte streams, bulk byte
  streams) to the user-logic bus and to target configuration ports.
  assumes the usb core delivers decoded setup packets and bulk bytes on
  this clock; done inputs come from pins and are synchronised here.
*/
`timescale 1ns/1ns
// Contract
// - bulk out bytes form five-byte records: code 0x00 address, 0x01 data
// - an address record loads its four bytes into the address register
// - words travel least significant byte first in both directions
// - a data record writes its word at the address, then address plus one
// - a bulk read advances the address by one per word returned
// - user-bus accesses start only because of host requests
// - only vendor-type control requests are taken; request field selects
// - clear request erases the target numbered by the value field
// - select request picks the target from its data byte and clears it
// - deselect request drops every target and returns its done status
// - register access writes its data byte to the addressed register
// - anything besides vendor requests and bulk streams is ignored
// - config check returns a character telling if the target is configured
// - board type request returns one identifying byte
// - media load request starts the media configuration sequence
// - firmware revision request returns a revision code
// - while a target is selected each bulk byte gets one strobe
module usb_to_user_bus_bridge #(
  parameter int         N_TARGETS  = 3,
  parameter logic [7:0] BOARD_TYPE = 8'h5a, // arbitrary value
  parameter logic [7:0] FW_REV     = 8'h01  // arbitrary value
) (
  input  wire logic                   clk,
  input  wire logic                   nrst,
  // decoded setup packet
  input  wire logic                   setup_valid,
  input  wire logic [7:0]             setup_type,
  input  wire logic [7:0]             setup_request,
  input  wire logic [15:0]            setup_value,
  // ep0 data stages
  input  wire logic                   ep0_out_valid,
  input  wire logic [7:0]             ep0_out_data,
  output logic                        ep0_in_valid,
  input  wire logic                   ep0_in_ready,
  output logic [7:0]                  ep0_in_data,
  // command_out_endpoint byte stream
  input  wire logic                   out_valid,
  output logic                        out_ready,
  input  wire logic [7:0]             out_data,
  // read_in_endpoint byte stream
  output logic                        in_valid,
  input  wire logic                   in_ready,
  output logic [7:0]                  in_data,
  // user bus
  output logic                        bus_req,
  output logic                        bus_write,
  output logic [31:0]                 bus_addr,
  output logic [31:0]                 bus_wdata,
  input  wire logic                   bus_ack,
  input  wire logic [31:0]            bus_rdata,
  // target configuration
  output logic [N_TARGETS-1:0]        target_clear,
  output logic [N_TARGETS-1:0]        target_select,
  output logic [7:0]                  cfg_data,
  output logic                        config_byte_strobe,
  input  wire logic [N_TARGETS-1:0]   target_done,
  output logic                        media_load_start,
  // configuration register write port
  output logic                        cfg_reg_wr,
  output logic [15:0]                 cfg_reg_addr,
  output logic [7:0]                  cfg_reg_data
);
  import usb_bridge_pkg::*;

  typedef struct packed {
    logic [2:0]           rec_cnt;
    logic                 rec_is_addr;
    logic                 rec_is_data;
    logic [31:0]          rec_word;
    logic [31:0]          addr;
    logic                 bus_req;
    logic                 bus_write;
    logic [31:0]          bus_addr;
    logic [31:0]          bus_wdata;
    logic [13:0]          rd_left;
    logic [1:0]           byte_idx;
    logic [N_TARGETS-1:0] sel_vec;
    logic [N_TARGETS-1:0] tclear;
    logic [7:0]           cfg_data;
    logic                 cfg_strobe;
    logic                 wait_data;
    logic [7:0]           pend_req;
    logic [15:0]          pend_value;
    logic                 resp_valid;
    logic [7:0]           resp_data;
    logic [7:0]           bus_disable;
    logic                 media_load;
    logic                 reg_wr;
    logic [15:0]          reg_addr;
    logic [7:0]           reg_data;
    logic [N_TARGETS-1:0] done_s1;
    logic [N_TARGETS-1:0] done_s2;
  } state_s;

  state_s      st_reg;
  state_s      st_next;
  logic        out_fire;
  logic        vendor;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic        fifo_pop;
  logic [31:0] fifo_out_data;
  logic        rd_push;
  logic        bus_idle;
  logic [31:0] asm_word;

  // index to one-hot, empty for an out-of-range target
  function automatic logic [N_TARGETS-1:0] onehot(input logic [15:0] idx);
    logic [N_TARGETS-1:0] v;
    v = '0;
    for (int i = 0; i < N_TARGETS; i++) begin
      if (idx == 16'(i)) begin
        v[i] = 1'b1;
      end
    end
    return v;
  endfunction : onehot

  // set-aside: reads stall the record parser so records keep their order
  assign bus_idle  = !st_reg.bus_req && st_reg.rd_left == '0;
  assign out_ready = (|st_reg.sel_vec) ? !st_reg.cfg_strobe :
                     (bus_idle && st_reg.bus_disable == '0);
  assign out_fire  = out_valid && out_ready;
  assign vendor    = setup_type[TYPE_LSB +: 2] == TYPE_VENDOR;
  assign asm_word  = {out_data, st_reg.rec_word[31:8]};
  assign rd_push   = st_reg.bus_req && bus_ack && !st_reg.bus_write;

  // read words go out one byte at a time, low byte first
  assign in_valid  = fifo_out_valid;
  assign in_data   = fifo_out_data[8*st_reg.byte_idx +: 8];
  assign fifo_pop  = in_valid && in_ready && st_reg.byte_idx == LAST_BYTE_IDX;

  word_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_read_fifo (
    .clk       (clk),
    .nrst      (nrst),
    .in_valid  (rd_push),
    .in_ready  (fifo_in_ready),
    .in_data   (bus_rdata),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data)
  );

  // all next-state logic; later assignments take priority
  always_comb begin
    st_next            = st_reg;
    st_next.tclear     = '0;
    st_next.cfg_strobe = 1'b0;
    st_next.media_load = 1'b0;
    st_next.reg_wr     = 1'b0;
    st_next.done_s1    = target_done;
    st_next.done_s2    = st_reg.done_s1;

    if (in_valid && in_ready) begin
      st_next.byte_idx = st_reg.byte_idx + 2'h1;
    end

    // bus completion
    if (st_reg.bus_req && bus_ack) begin
      st_next.bus_req = 1'b0;
    end

    // bulk out: configuration bytes or records
    if (out_fire && (|st_reg.sel_vec)) begin
      st_next.cfg_data   = out_data;
      st_next.cfg_strobe = 1'b1;
    end else if (out_fire && st_reg.rec_cnt == '0) begin
      st_next.rec_is_addr = out_data == REC_ADDRESS;
      st_next.rec_is_data = out_data == REC_DATA;
      st_next.rec_cnt     = 3'h1;
    end else if (out_fire && st_reg.rec_cnt != REC_PAYLOAD) begin
      st_next.rec_word = asm_word;
      st_next.rec_cnt  = st_reg.rec_cnt + 3'h1;
    end else if (out_fire) begin
      st_next.rec_cnt = '0;
      if (st_reg.rec_is_addr) begin
        st_next.addr = asm_word;
      end
      if (st_reg.rec_is_data) begin
        st_next.bus_req   = 1'b1;
        st_next.bus_write = 1'b1;
        st_next.bus_addr  = st_reg.addr;
        st_next.bus_wdata = asm_word;
        st_next.addr      = st_reg.addr + 32'h1;
      end
    end

    // read fetch, only while a host read length is pending
    if (st_reg.rd_left != '0 && !st_reg.bus_req && fifo_in_ready &&
        st_reg.bus_disable == '0) begin
      st_next.bus_req   = 1'b1;
      st_next.bus_write = 1'b0;
      st_next.bus_addr  = st_reg.addr;
      st_next.addr      = st_reg.addr + 32'h1;
      st_next.rd_left   = st_reg.rd_left - 14'h1;
    end

    // ep0 answer leaves once taken; a new answer wins over the clear
    if (ep0_in_ready) begin
      st_next.resp_valid = 1'b0;
    end

    // ep0 data stage of select and register access
    if (st_reg.wait_data && ep0_out_valid) begin
      st_next.wait_data = 1'b0;
      if (st_reg.pend_req == REQ_SELECT) begin
        st_next.sel_vec = onehot({8'h00, ep0_out_data});
        st_next.tclear  = onehot({8'h00, ep0_out_data});
      end else begin
        st_next.reg_wr   = 1'b1;
        st_next.reg_addr = st_reg.pend_value;
        st_next.reg_data = ep0_out_data;
        if (st_reg.pend_value == REG_USER_BUS_DISABLE) begin
          st_next.bus_disable = ep0_out_data;
        end
      end
    end

    // setup decode: non-vendor requests fall through untouched
    if (setup_valid && vendor) begin
      unique case (setup_request)
        REQ_CLEAR: begin
          st_next.tclear = onehot(setup_value);
        end
        REQ_SELECT: begin
          st_next.wait_data = 1'b1;
          st_next.pend_req  = setup_request;
        end
        REQ_DESELECT: begin
          st_next.sel_vec    = '0;
          st_next.resp_valid = 1'b1;
          st_next.resp_data  = {7'h00, |(st_reg.done_s2 & st_reg.sel_vec)};
        end
        REQ_REG_ACCESS: begin
          if (setup_type[DIR_BIT]) begin
            st_next.resp_valid = 1'b1;
            st_next.resp_data  = (setup_value == REG_USER_BUS_DISABLE) ?
                                 st_reg.bus_disable : 8'h00;
          end else begin
            st_next.wait_data  = 1'b1;
            st_next.pend_req   = setup_request;
            st_next.pend_value = setup_value;
          end
        end
        REQ_READ_LENGTH: begin
          // byte count to words; a trailing partial word is dropped
          st_next.rd_left = setup_value[15:WORD_BYTES_LOG2];
          st_next.byte_idx = '0;
        end
        REQ_CONFIG_CHECK: begin
          st_next.resp_valid = 1'b1;
          st_next.resp_data  = (|(st_reg.done_s2 & st_reg.sel_vec)) ?
                               CHAR_CONFIGURED : CHAR_UNCONFIGURED;
        end
        REQ_BOARD_TYPE: begin
          st_next.resp_valid = 1'b1;
          st_next.resp_data  = BOARD_TYPE;
        end
        REQ_MEDIA_LOAD: begin
          st_next.media_load = 1'b1;
        end
        REQ_FW_REVISION: begin
          st_next.resp_valid = 1'b1;
          st_next.resp_data  = FW_REV;
        end
        default: begin
          // undocumented requests are ignored
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_reg             <= '0;
      st_reg.addr        <= RST_ADDRESS;
      st_reg.bus_disable <= RST_USER_BUS_DISABLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from state flops
  assign ep0_in_valid       = st_reg.resp_valid;
  assign ep0_in_data        = st_reg.resp_data;
  assign bus_req            = st_reg.bus_req;
  assign bus_write          = st_reg.bus_write;
  assign bus_addr           = st_reg.bus_addr;
  assign bus_wdata          = st_reg.bus_wdata;
  assign target_clear       = st_reg.tclear;
  assign target_select      = st_reg.sel_vec;
  assign cfg_data           = st_reg.cfg_data;
  assign config_byte_strobe = st_reg.cfg_strobe;
  assign media_load_start   = st_reg.media_load;
  assign cfg_reg_wr         = st_reg.reg_wr;
  assign cfg_reg_addr       = st_reg.reg_addr;
  assign cfg_reg_data       = st_reg.reg_data;

  // checks on the bridge's own outputs
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  logic rec_last;
  assign rec_last = out_fire && !(|st_reg.sel_vec) && st_reg.rec_cnt == REC_PAYLOAD;

  property p_addr_load;
    rec_last && st_reg.rec_is_addr |=> st_reg.addr == $past(asm_word);
  endproperty
  a_addr_load: assert property (p_addr_load)
    else $error("address record not loaded");

  property p_data_write;
    rec_last && st_reg.rec_is_data |=> bus_req && bus_write &&
      bus_wdata == $past(asm_word) && st_reg.addr == bus_addr + 32'h1;
  endproperty
  a_data_write: assert property (p_data_write)
    else $error("data record write wrong");

  property p_read_step;
    $rose(bus_req) && !bus_write |-> st_reg.addr == bus_addr + 32'h1 &&
      st_reg.rd_left == $past(st_reg.rd_left) - 14'h1;
  endproperty
  a_read_step: assert property (p_read_step)
    else $error("read did not advance address");

  property p_no_spont;
    $rose(bus_req) |-> $past(rec_last) || $past(st_reg.rd_left) != '0;
  endproperty
  a_no_spont: assert property (p_no_spont)
    else $error("bus access without host request");

  property p_strobe;
    config_byte_strobe |-> !$past(config_byte_strobe) && cfg_data == $past(out_data);
  endproperty
  a_strobe: assert property (p_strobe)
    else $error("configuration strobe wrong");

  property p_non_vendor;
    setup_valid && !vendor && !st_reg.wait_data |=> target_clear == '0 &&
      $stable(target_select) && !media_load_start;
  endproperty
  a_non_vendor: assert property (p_non_vendor)
    else $error("non-vendor request acted on");

  property p_clear;
    setup_valid && vendor && setup_request == REQ_CLEAR |=>
      target_clear == onehot($past(setup_value));
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear pulse wrong");

  property p_deselect;
    setup_valid && vendor && setup_request == REQ_DESELECT |=>
      target_select == '0 && ep0_in_valid;
  endproperty
  a_deselect: assert property (p_deselect)
    else $error("deselect failed");

  property p_reg_write;
    st_reg.wait_data && ep0_out_valid && st_reg.pend_req == REQ_REG_ACCESS |=>
      cfg_reg_wr && cfg_reg_addr == $past(st_reg.pend_value) &&
      cfg_reg_data == $past(ep0_out_data);
  endproperty
  a_reg_write: assert property (p_reg_write)
    else $error("register write wrong");

  property p_hold;
    bus_req && !bus_ack |=> bus_req && $stable(bus_addr) && $stable(bus_wdata);
  endproperty
  a_hold: assert property (p_hold)
    else $error("bus request dropped early");
endmodule : usb_to_user_bus_bridge

/* user_bus_model.sv */
/*
  user-bus controller model facing the bridge: acks each access after a
  settable number of wait cycles and answers reads from an address pattern.
  assumes the bridge holds bus_req and its qualifiers until bus_ack.
*/
`timescale 1ns/1ns
module user_bus_model (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [3:0]  wait_cycles,
  input  wire logic        bus_req,
  input  wire logic        bus_write,
  input  wire logic [31:0] bus_addr,
  output logic             bus_ack,
  output logic [31:0]      bus_rdata
);
  logic [3:0] cnt_reg;

  // upper half scrambled so a byte-order slip cannot match
  function automatic logic [31:0] word_of(input logic [31:0] a);
    return {a[15:0] ^ 16'hc3a5, a[15:0]};
  endfunction : word_of

  // rdata toggles when idle so a stale sample never passes
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bus_ack   <= 1'b0;
      cnt_reg   <= 4'h0;
      bus_rdata <= 32'h0000_0000;
    end else begin
      bus_ack   <= 1'b0;
      bus_rdata <= ~bus_rdata;
      if (bus_req && !bus_ack) begin
        if (cnt_reg >= wait_cycles) begin
          bus_ack <= 1'b1;
          cnt_reg <= 4'h0;
          if (!bus_write) bus_rdata <= word_of(bus_addr);
        end else begin
          cnt_reg <= cnt_reg + 4'h1;
        end
      end
    end
  end
endmodule : user_bus_model

/* usb_to_user_bus_bridge_bench.sv */
/*
  self-checking bench for the usb-to-user-bus bridge: setup, ep0 and bulk
  streams driven here, the user bus answered by user_bus_model.
  assumes the package, word_fifo and the model are compiled first.
*/
`timescale 1ns/1ns
module usb_to_user_bus_bridge_bench;
  import usb_bridge_pkg::*;
  localparam logic [7:0] BOARD = 8'h3c; // arbitrary value
  localparam logic [7:0] REV   = 8'h07; // arbitrary value
  localparam logic [7:0] T_OUT = {1'b0, TYPE_VENDOR, 5'h00};
  localparam logic [7:0] T_IN  = {1'b1, TYPE_VENDOR, 5'h00};
  logic        clk, nrst, setup_valid, ep0_out_valid, ep0_in_valid, ep0_in_ready, out_valid;
  logic        out_ready, in_valid, in_ready, bus_req, bus_write, bus_ack, cfg_reg_wr;
  logic        config_byte_strobe, media_load_start;
  logic [7:0]  setup_type, setup_request, ep0_out_data, ep0_in_data, out_data, in_data;
  logic [7:0]  cfg_data, cfg_reg_data, bq[$], strobes[$];
  logic [15:0] setup_value, cfg_reg_addr, seed;
  logic [31:0] bus_addr, bus_wdata, bus_rdata, base, r, dv[3];
  logic [2:0]  target_clear, target_select, target_done, clr_seen;
  logic [3:0]  wait_cycles;
  logic [23:0] regw;
  logic [63:0] wlog[$];
  int          n_fail, checks, n_rd, n_media, j, k, n;

  usb_to_user_bus_bridge #(.N_TARGETS(3), .BOARD_TYPE(BOARD), .FW_REV(REV))
  u_usb_to_user_bus_bridge (
    .clk(clk), .nrst(nrst), .setup_valid(setup_valid), .setup_type(setup_type),
    .setup_request(setup_request), .setup_value(setup_value), .ep0_out_valid(ep0_out_valid),
    .ep0_out_data(ep0_out_data), .ep0_in_valid(ep0_in_valid), .ep0_in_ready(ep0_in_ready),
    .ep0_in_data(ep0_in_data), .out_valid(out_valid), .out_ready(out_ready),
    .out_data(out_data), .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data),
    .bus_req(bus_req), .bus_write(bus_write), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_ack(bus_ack), .bus_rdata(bus_rdata), .target_clear(target_clear),
    .target_select(target_select), .cfg_data(cfg_data),
    .config_byte_strobe(config_byte_strobe), .target_done(target_done),
    .media_load_start(media_load_start), .cfg_reg_wr(cfg_reg_wr),
    .cfg_reg_addr(cfg_reg_addr), .cfg_reg_data(cfg_reg_data));

  user_bus_model u_user_bus_model (
    .clk(clk), .nrst(nrst), .wait_cycles(wait_cycles), .bus_req(bus_req),
    .bus_write(bus_write), .bus_addr(bus_addr), .bus_ack(bus_ack), .bus_rdata(bus_rdata));

  // clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // logs of pulses and completed accesses, read before the edge's updates land
  always @(posedge clk) begin
    if (bus_req === 1'b1 && bus_ack === 1'b1 && bus_write === 1'b1) wlog.push_back({bus_addr, bus_wdata});
    if (bus_req === 1'b1 && bus_ack === 1'b1 && bus_write === 1'b0) n_rd <= n_rd + 1;
    if (target_clear !== 3'h0) clr_seen <= target_clear;
    if (media_load_start === 1'b1) n_media <= n_media + 1;
    if (config_byte_strobe === 1'b1) strobes.push_back(cfg_data);
    if (cfg_reg_wr === 1'b1) regw <= {cfg_reg_addr, cfg_reg_data};
  end

  task automatic close_out;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t %s: got %h expected %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic tout(input string m);
    n_fail++;
    $display("ERROR %0t %s: no progress", $time, m);
    close_out();
  endtask : tout

  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick

  // 16-bit lfsr, two steps per word
  function automatic void rnd(output logic [31:0] w);
    repeat (2) begin
      seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
      w = {w[15:0], seed};
    end
  endfunction : rnd

  function automatic logic [31:0] exp_word(input logic [31:0] a);
    return {a[15:0] ^ 16'hc3a5, a[15:0]};
  endfunction : exp_word

  task automatic setup(input logic [7:0] t, input logic [7:0] q, input logic [15:0] v);
    {setup_type, setup_request, setup_value, setup_valid} = {t, q, v, 1'b1};
    tick();
    setup_valid = 1'b0;
    tick();
  endtask : setup

  task automatic ep0_byte(input logic [7:0] b);
    {ep0_out_data, ep0_out_valid} = {b, 1'b1};
    tick();
    ep0_out_valid = 1'b0;
    tick();
  endtask : ep0_byte

  task automatic answer(input logic [7:0] exp, input string m);
    int i;
    for (i = 0; i < 20 && ep0_in_valid !== 1'b1; i++) tick();
    if (i == 20) tout(m);
    chk(ep0_in_data, exp, m);
    ep0_in_ready = 1'b1;
    tick();
    ep0_in_ready = 1'b0;
  endtask : answer

  task automatic rec(input logic [7:0] c, input logic [31:0] w);
    bq.push_back(c);
    for (int b = 0; b < 4; b++) bq.push_back(w[8*b +: 8]);
  endtask : rec

  // bulk out to the command endpoint: every queued byte, then wait for the bus to go idle
  task automatic flush;
    int i;
    while (bq.size() > 0) begin
      out_valid = 1'b1;
      out_data  = bq.pop_front();
      for (i = 0; i < 200 && out_ready !== 1'b1; i++) tick();
      if (i == 200) tout("bulk out");
      tick();
    end
    out_valid = 1'b0;
    for (i = 0, j = 0; i < 200 && j < 3; i++) begin
      tick();
      j = (out_ready === 1'b1 && bus_req === 1'b0) ? j + 1 : 0;
    end
    if (j < 3) tout("bus idle");
  endtask : flush

  task automatic get_word(output logic [31:0] w);
    int i;
    for (int b = 0; b < 4; b++) begin
      for (i = 0; i < 200 && in_valid !== 1'b1; i++) begin
        in_ready = 1'b0;
        tick();
      end
      if (i == 200) tout("bulk in");
      w[8*b +: 8] = in_data;
      in_ready = 1'b1;
      tick();
    end
  endtask : get_word

  initial begin
    {nrst, setup_valid, ep0_out_valid, ep0_in_ready, out_valid, in_ready} = 6'h00;
    {setup_type, setup_request, setup_value, ep0_out_data, out_data} = 48'h0;
    {target_done, seed, wait_cycles, clr_seen} = {3'b100, 16'h0017, 4'h0, 3'h0};
    {n_fail, checks, n_rd, n_media} = {32'h0, 32'h0, 32'h0, 32'h0};
    repeat (6) @(posedge clk);
    #1 nrst = 1'b1;
    chk({out_ready, in_valid, bus_req}, 3'b100, "reset levels");
    tick();
    // writes with a bad record among them
    rnd(base);
    rnd(r);
    wait_cycles = r[3:0] & 4'h3;
    for (k = 0; k < 3; k++) rnd(dv[k]);
    rec(REC_ADDRESS, base);
    rec(REC_DATA, dv[0]);
    rec(REC_DATA, dv[1]);
    rec(8'h07, dv[1]);
    rec(REC_DATA, dv[2]);
    flush();
    chk(wlog.size(), 3, "write count");
    for (k = 0; k < 3; k++) chk(wlog[k][63:32], base + k, "write address");
    for (k = 0; k < 3; k++) chk(wlog[k][31:0], dv[k], "write data");
    $display("test writes done");
    // short read, then a write that must land past it
    setup(T_OUT, REQ_READ_LENGTH, 16'h0008);
    for (k = 0; k < 2; k++) begin
      get_word(r);
      chk(r, exp_word(base + 3 + k), "read word");
    end
    in_ready = 1'b0;
    rec(REC_DATA, dv[0]);
    flush();
    chk(wlog[3][63:32], base + 5, "address after read");
    $display("test read done");
    // fifo fills while the host stalls, then drains
    n_rd = 0;
    setup(T_OUT, REQ_READ_LENGTH, 16'h0048);
    repeat (200) tick();
    chk(n_rd, FIFO_DEPTH, "reads held by full fifo");
    for (k = 0; k < 18; k++) begin
      get_word(r);
      chk(r, exp_word(base + 6 + k), "drained word");
    end
    in_ready = 1'b0;
    tick();
    chk(in_valid, 1'b0, "fifo empty");
    $display("test fifo done");
    // target control
    setup(8'h00, REQ_CLEAR, 16'h0001);
    repeat (3) tick();
    chk(clr_seen, 3'h0, "standard request ignored");
    for (k = 0; k < 4; k++) begin
      clr_seen = 3'h0;
      setup(T_OUT, REQ_CLEAR, k[15:0]);
      repeat (3) tick();
      chk(clr_seen, (k < 3) ? 3'b001 << k : 3'h0, "clear target");
    end
    for (k = 2; k >= 0; k -= 2) begin
      clr_seen = 3'h0;
      strobes.delete();
      n = wlog.size();
      setup(T_OUT, REQ_SELECT, 16'h0000);
      ep0_byte(k[7:0]);
      repeat (3) tick();
      chk(target_select, 3'b001 << k, "select");
      chk(clr_seen, 3'b001 << k, "select clears");
      setup(T_IN, REQ_CONFIG_CHECK, 16'h0000);
      answer(target_done[k] ? CHAR_CONFIGURED : CHAR_UNCONFIGURED, "config check");
      rnd(r);
      for (j = 0; j < 4; j++) bq.push_back(r[8*j +: 8]);
      flush();
      chk(strobes.size(), 4, "strobe count");
      for (j = 0; j < 4; j++) chk(strobes[j], r[8*j +: 8], "config byte");
      chk(wlog.size(), n, "no bus write while selected");
      setup(T_IN, REQ_DESELECT, 16'h0000);
      answer({7'h00, target_done[k]}, "deselect status");
      chk(target_select, 3'h0, "deselected");
    end
    $display("test targets done");
    // identity, media and register requests
    setup(T_IN, REQ_BOARD_TYPE, 16'h0000);
    answer(BOARD, "board type");
    setup(T_IN, REQ_FW_REVISION, 16'h0000);
    answer(REV, "revision");
    setup(T_OUT, REQ_MEDIA_LOAD, 16'h0000);
    tick();
    chk(n_media, 1, "media load");
    setup(T_IN, REQ_REG_ACCESS, REG_USER_BUS_DISABLE);
    answer(RST_USER_BUS_DISABLE, "register reset");
    setup(T_OUT, REQ_REG_ACCESS, REG_USER_BUS_DISABLE);
    ep0_byte(8'h01);
    chk(regw, {REG_USER_BUS_DISABLE, 8'h01}, "register write");
    setup(T_IN, REQ_REG_ACCESS, REG_USER_BUS_DISABLE);
    answer(8'h01, "register readback");
    chk(out_ready, 1'b0, "user bus disabled");
    setup(T_IN, REQ_REG_ACCESS, 16'h0010);
    answer(8'h00, "unmapped register");
    setup(T_OUT, REQ_REG_ACCESS, REG_USER_BUS_DISABLE);
    ep0_byte(8'h00);
    chk(out_ready, 1'b1, "user bus enabled");
    $display("test requests done");
    close_out();
  end
endmodule : usb_to_user_bus_bridge_bench
